/* rtl/dpo_top.sv */
// Output-side control of a two-lane deserializer: lock, word assembly,
// recovered clock, launch edge, tri-state control, APB registers, IRQ.
// Assumes the link and control pins are asynchronous to CORE_CLK and the link clock is
// much slower than CORE_CLK (400 ns against 50 ns).
//
// Summary of operation
// - Lock output low until lock, then high
// - No lock tri-states data bus and clock
// - Edge select high rising, low falling update
// - Output enable low tri-states, recovery keeps running
// - Power-down low tri-states all, stops recovery
// - Clock output runs at parallel word rate
// - Thirty-two bit word, bit 31 most significant
// - Serializer edge select mirrors this choice
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "dpo_defs.svh"

module dpo_top
    import dpo_pkg::*;
(
    input  wire logic        CORE_CLK,             // Core clock, 20 MHz
    input  wire logic        RESETN,               // Async reset, active low
    input  wire logic        LINK_CLK,             // Link bit clock from serializer
    input  wire logic [1:0]  SERIAL_LANE_IN,       // Two serial data lanes
    input  wire logic        OUTPUT_EDGE_SELECT,   // 1 rising, 0 falling launch
    input  wire logic        OUTPUT_ENABLE,        // Output enable, active high
    input  wire logic        POWER_DOWN_N,         // Standby when low
    input  wire logic        RESERVED_TIE_LOW,     // Must be held low
    output logic      [31:0] RECOVERED_DATA_OUT,   // Parallel word
    output logic             RECOVERED_DATA_OE_N,  // Low while data driven
    output logic             RECOVERED_CLOCK_OUT,  // Word-rate clock
    output logic             RECOVERED_CLOCK_OE_N, // Low while clock driven
    output logic             LOCK_OUT,             // Lock status
    output logic             LOCK_OE_N,            // Low while lock driven
    output logic             IRQ,                  // Level interrupt
    input  wire logic        PSEL,                 // APB select
    input  wire logic        PENABLE,              // APB enable
    input  wire logic        PWRITE,               // APB direction
    input  wire logic [11:0] PADDR,                // APB byte address
    input  wire logic [31:0] PWDATA,               // APB write data
    output logic      [31:0] PRDATA,               // APB read data
    output logic             PREADY,               // APB ready
    output logic             PSLVERR               // APB error on unmapped
);

    // Synchroniser stages and link edge finder
    dpo_pins_t   pins_s1_q;
    dpo_pins_t   pins_s2_q;
    logic        link_prev_q;

    // Clock-recovery state
    dpo_state_t  state_q,    state_d;
    logic [5:0]  edge_cnt_q, edge_cnt_d;
    logic [6:0]  idle_cnt_q, idle_cnt_d;
    logic [3:0]  bit_cnt_q,  bit_cnt_d;
    logic [15:0] lo_q,       lo_d;
    logic [15:0] hi_q,       hi_d;
    logic [31:0] word_q,     word_d;
    logic        rclk_q,     rclk_d;

    // Output stage
    logic        rclk_prev_q;
    logic [31:0] out_q,      out_d;
    logic        drive_q,    drive_d;
    logic        stby_q,     stby_d;

    // Register file
    logic [1:0]  ctrl_q,     ctrl_d;
    logic [`DPO_IRQ_W-1:0] istat_q, istat_d;
    logic [`DPO_IRQ_W-1:0] imask_q, imask_d;
    logic [31:0] rdata_q,    rdata_d;

    // Combinational helpers
    logic        link_rise;
    logic        standby;
    logic        timeout;
    logic        ev_lock;
    logic        ev_loss;
    logic        ev_word;
    logic        launch;
    logic        wr_acc;
    logic        rd_setup;
    logic        mapped;
    logic [`DPO_IRQ_W-1:0] events;

    // Two-flop synchroniser; only stage two is ever read
    always_ff @(posedge CORE_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            pins_s1_q   <= '0;
            pins_s2_q   <= '0;
            link_prev_q <= 1'b0;
        end
        else
        begin
            pins_s1_q   <= {LINK_CLK, SERIAL_LANE_IN, OUTPUT_EDGE_SELECT,
                            OUTPUT_ENABLE, POWER_DOWN_N, RESERVED_TIE_LOW};
            pins_s2_q   <= pins_s1_q;
            link_prev_q <= pins_s2_q.link_clk;
        end
    end

    // Standby from pin or software; pin power-down always wins
    assign link_rise = pins_s2_q.link_clk & ~link_prev_q;
    assign standby   = ~pins_s2_q.pwr_n | ctrl_q[`DPO_CTRL_STBY];
    assign timeout   = (idle_cnt_q == 7'(`DPO_LOSS_CYC));

    // Clock recovery: acquire on steady edges, frame 16 bits per lane
    always_comb
    begin
        state_d    = state_q;
        edge_cnt_d = edge_cnt_q;
        idle_cnt_d = idle_cnt_q;
        bit_cnt_d  = bit_cnt_q;
        lo_d       = lo_q;
        hi_d       = hi_q;
        word_d     = word_q;
        rclk_d     = rclk_q;
        ev_lock    = 1'b0;
        ev_loss    = 1'b0;
        ev_word    = 1'b0;
        if (link_rise)
            idle_cnt_d = '0;
        else if (!timeout)
            idle_cnt_d = idle_cnt_q + 7'h01;
        case (state_q)
            DPO_ST_OFF:
            begin
                edge_cnt_d = '0;
                idle_cnt_d = '0;
                bit_cnt_d  = '0;
                rclk_d     = 1'b0;
                if (!standby)
                    state_d = DPO_ST_ACQ;
            end
            DPO_ST_ACQ:
            begin
                // Lock only after a run of edges without a gap; the edge that
                // ends a long gap opens a fresh run rather than being dropped
                if (link_rise)
                begin
                    edge_cnt_d = timeout ? 6'h01 : edge_cnt_q + 6'h01;
                    if (!timeout && (edge_cnt_q == `DPO_LOCK_LAST))
                    begin
                        state_d   = DPO_ST_LOCK;
                        bit_cnt_d = '0;
                        ev_lock   = 1'b1;
                    end
                end
                else if (timeout)
                    edge_cnt_d = '0;
            end
            DPO_ST_LOCK:
            begin
                if (timeout)
                begin
                    state_d    = DPO_ST_ACQ;
                    edge_cnt_d = {5'h0, link_rise}; // Edge ending the gap opens a run
                    rclk_d     = 1'b0;
                    ev_loss    = 1'b1;
                end
                else if (link_rise)
                begin
                    // LSB first on each lane; lane 1 carries the upper half
                    lo_d      = {pins_s2_q.lane[0], lo_q[15:1]};
                    hi_d      = {pins_s2_q.lane[1], hi_q[15:1]};
                    bit_cnt_d = bit_cnt_q + 4'h1;
                    if (bit_cnt_q == `DPO_BIT_LAST)
                    begin
                        word_d  = {hi_d, lo_d};
                        ev_word = 1'b1;
                    end
                    rclk_d = (bit_cnt_d < `DPO_CLK_HALF);
                end
            end
            default:
                state_d = DPO_ST_OFF;
        endcase
        if (standby)
        begin
            // Power-down shuts recovery; lock must be earned again
            if (state_q == DPO_ST_LOCK)
                ev_loss = 1'b1;
            state_d = DPO_ST_OFF;
            rclk_d  = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_q    <= DPO_ST_OFF;
            edge_cnt_q <= '0;
            idle_cnt_q <= '0;
            bit_cnt_q  <= '0;
            lo_q       <= '0;
            hi_q       <= '0;
            word_q     <= '0;
            rclk_q     <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            edge_cnt_q <= edge_cnt_d;
            idle_cnt_q <= idle_cnt_d;
            bit_cnt_q  <= bit_cnt_d;
            lo_q       <= lo_d;
            hi_q       <= hi_d;
            word_q     <= word_d;
            rclk_q     <= rclk_d;
        end
    end

    // Launch on the chosen edge of the recovered clock
    assign launch = pins_s2_q.edge_sel ? (rclk_q & ~rclk_prev_q)
                                       : (~rclk_q & rclk_prev_q);

    // Output stage; enables follow lock, enable pin and power-down
    always_comb
    begin
        out_d   = launch ? word_q : out_q;
        stby_d  = standby;
        drive_d = (state_q == DPO_ST_LOCK) & ~standby
                & pins_s2_q.out_en & ctrl_q[`DPO_CTRL_OE];
    end

    always_ff @(posedge CORE_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rclk_prev_q <= 1'b0;
            out_q       <= '0;
            drive_q     <= 1'b0;
            stby_q      <= 1'b1;
        end
        else
        begin
            rclk_prev_q <= rclk_q;
            out_q       <= out_d;
            drive_q     <= drive_d;
            stby_q      <= stby_d;
        end
    end

    assign RECOVERED_DATA_OUT   = out_q;
    assign RECOVERED_CLOCK_OUT  = rclk_q;
    assign RECOVERED_DATA_OE_N  = ~drive_q;
    assign RECOVERED_CLOCK_OE_N = ~drive_q;
    assign LOCK_OUT             = (state_q == DPO_ST_LOCK);
    assign LOCK_OE_N            = stby_q;

    // APB decode: zero-wait, read data latched in the setup cycle
    assign wr_acc   = PSEL & PENABLE & PWRITE;
    assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
    assign mapped   = (PADDR == `DPO_ADDR_CTRL)  || (PADDR == `DPO_ADDR_STAT)
                   || (PADDR == `DPO_ADDR_ISTAT) || (PADDR == `DPO_ADDR_IMASK)
                   || (PADDR == `DPO_ADDR_WORD);

    // Tied-high reserved pin is flagged as a board fault
    assign events = {ev_word, pins_s2_q.reserved_tie_low, ev_loss, ev_lock};

    // Registers; a new event beats a write-one-to-clear in the same cycle
    always_comb
    begin
        ctrl_d  = ctrl_q;
        imask_d = imask_q;
        istat_d = istat_q;
        rdata_d = rdata_q;
        if (wr_acc)
        begin
            if (PADDR == `DPO_ADDR_CTRL)
                ctrl_d = PWDATA[1:0];
            else if (PADDR == `DPO_ADDR_IMASK)
                imask_d = PWDATA[`DPO_IRQ_W-1:0];
            else if (PADDR == `DPO_ADDR_ISTAT)
                istat_d = istat_q & ~PWDATA[`DPO_IRQ_W-1:0];
        end
        istat_d = istat_d | events;
        if (rd_setup)
        begin
            if (PADDR == `DPO_ADDR_CTRL)
                rdata_d = {30'h0, ctrl_q};
            else if (PADDR == `DPO_ADDR_STAT)
                rdata_d = {27'h0, (state_q == DPO_ST_ACQ), pins_s2_q.edge_sel,
                           stby_q, drive_q, (state_q == DPO_ST_LOCK)};
            else if (PADDR == `DPO_ADDR_ISTAT)
                rdata_d = {28'h0, istat_q};
            else if (PADDR == `DPO_ADDR_IMASK)
                rdata_d = {28'h0, imask_q};
            else if (PADDR == `DPO_ADDR_WORD)
                rdata_d = word_q;
            else
                rdata_d = '0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ctrl_q  <= `DPO_CTRL_RST;
            imask_q <= '0;
            istat_q <= '0;
            rdata_q <= '0;
        end
        else
        begin
            ctrl_q  <= ctrl_d;
            imask_q <= imask_d;
            istat_q <= istat_d;
            rdata_q <= rdata_d;
        end
    end

    assign PRDATA  = rdata_q;
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;
    assign IRQ     = |(istat_q & imask_q);

endmodule : dpo_top

/* rtl/dpo_defs.svh */
// Constants of the deserializer parallel output controller.
// Assumes inclusion by bare name; holds definitions only.
`ifndef DPO_DEFS_SVH
`define DPO_DEFS_SVH

// APB register byte addresses
`define DPO_ADDR_CTRL   12'h000
`define DPO_ADDR_STAT   12'h004
`define DPO_ADDR_ISTAT  12'h008
`define DPO_ADDR_IMASK  12'h00c
`define DPO_ADDR_WORD   12'h010

// Control register fields and reset value
`define DPO_CTRL_OE      0
`define DPO_CTRL_STBY    1
`define DPO_CTRL_RST     2'h1

// Status register fields
`define DPO_STAT_LOCK    0
`define DPO_STAT_DRIVE   1
`define DPO_STAT_STBY    2
`define DPO_STAT_EDGE    3
`define DPO_STAT_ACQ     4

// Interrupt status and mask fields
`define DPO_IRQ_LOCK     0
`define DPO_IRQ_LOSS     1
`define DPO_IRQ_RESERVED_TIE_LOW     2
`define DPO_IRQ_WORD     3
`define DPO_IRQ_W        4

// Timing: core clock period and longest silence on the link clock
`define DPO_CLK_NS       50
`define DPO_LOSS_NS      2000
`define DPO_LOSS_CYC     (`DPO_LOSS_NS / `DPO_CLK_NS)

// Lock acquisition and word framing
`define DPO_LOCK_LAST    6'h1f
`define DPO_BIT_LAST     4'hf
`define DPO_CLK_HALF     4'h8

`endif

/* rtl/dpo_pkg.sv */
// Types of the deserializer parallel output controller.
// Assumes the constants header is compiled alongside.
package dpo_pkg;

    // Clock-recovery states, one-hot
    typedef enum logic [2:0]
    {
        DPO_ST_OFF  = 3'b001,
        DPO_ST_ACQ  = 3'b010,
        DPO_ST_LOCK = 3'b100
    } dpo_state_t;

    // Pin inputs that travel through the synchroniser together
    typedef struct packed
    {
        logic       link_clk;
        logic [1:0] lane;
        logic       edge_sel;
        logic       out_en;
        logic       pwr_n;
        logic       reserved_tie_low;
    } dpo_pins_t;

endpackage : dpo_pkg

/* bench/dpo_top_chk.sv */
// Concurrent checks on the pins of the output controller.
// Assumes binding into dpo_top; sees its ports only.
`timescale 1ns/1ps

module dpo_top_chk
(
    input wire logic        CORE_CLK,             // Core clock
    input wire logic        RESETN,               // Async reset, active low
    input wire logic        LINK_CLK,             // Link clock pin
    input wire logic        OUTPUT_EDGE_SELECT,   // Launch edge
    input wire logic        OUTPUT_ENABLE,        // Output enable
    input wire logic        POWER_DOWN_N,         // Standby when low
    input wire logic [31:0] RECOVERED_DATA_OUT,   // Word
    input wire logic        RECOVERED_DATA_OE_N,  // Data drive
    input wire logic        RECOVERED_CLOCK_OUT,  // Word clock
    input wire logic        RECOVERED_CLOCK_OE_N, // Clock drive
    input wire logic        LOCK_OUT,             // Lock
    input wire logic        LOCK_OE_N,            // Lock drive
    input wire logic        IRQ                   // Interrupt
);
    logic [6:0] sil_q;
    logic [6:0] sil_d;
    logic       lk_q;

    // Link silence count; saturates so a long idle never wraps
    always_comb
    begin
        sil_d = (LINK_CLK != lk_q) ? 7'h0 : ((sil_q == 7'h7f) ? sil_q : sil_q + 7'h1);
    end

    // Silence count registers
    always_ff @(posedge CORE_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            sil_q <= 7'h0;
            lk_q  <= 1'b0;
        end
        else
        begin
            sil_q <= sil_d;
            lk_q  <= LINK_CLK;
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    a_nolock_tri: assert property (!LOCK_OUT ##1 !LOCK_OUT |-> RECOVERED_DATA_OE_N)
        else $error("data driven without lock");
    a_clk_pair: assert property ((RECOVERED_CLOCK_OE_N == RECOVERED_DATA_OE_N)
        && (RECOVERED_CLOCK_OE_N || ($past(LOCK_OUT) && !LOCK_OE_N)))
        else $error("clock and data drive differ or lack lock");
    a_oe_low_tri: assert property (!OUTPUT_ENABLE [*4] |-> RECOVERED_DATA_OE_N)
        else $error("data driven with enable low");
    a_pd_standby: assert property (!POWER_DOWN_N [*6]
        |-> LOCK_OE_N && RECOVERED_DATA_OE_N)
        else $error("pins driven in standby");
    a_pd_relock: assert property ($rose(POWER_DOWN_N) |-> RECOVERED_DATA_OE_N [*8])
        else $error("driven before relock");
    a_silence_unlock: assert property (sil_q >= 7'h30 |-> !LOCK_OUT)
        else $error("lock held on silent link");
    a_clk_hold: assert property ($changed(RECOVERED_CLOCK_OUT)
        |=> $stable(RECOVERED_CLOCK_OUT) [*8])
        else $error("word clock too fast");
    a_launch_edge: assert property ($changed(RECOVERED_DATA_OUT) && !RECOVERED_DATA_OE_N
        |-> RECOVERED_CLOCK_OUT == OUTPUT_EDGE_SELECT)
        else $error("word launched on wrong edge");

    c_lock: cover property ($rose(LOCK_OUT));
    c_drive: cover property ($fell(RECOVERED_DATA_OE_N));
    c_irq: cover property ($rose(IRQ));
endmodule : dpo_top_chk

bind dpo_top dpo_top_chk u_chk (.*);

/* bench/dpo_ser_model.sv */
// Companion serializer: link clock and two lanes, LSB first.
// Assumes the bench calls send; the clock stands still between calls.
`timescale 1ns/1ps

module dpo_ser_model
(
    output logic       link_clk, // Link clock, 400 ns period
    output logic [1:0] lane      // Serial lanes
);
    // Lanes move after the fall so they settle before the rise
    task automatic send(input int n, input logic [31:0] w);
        #7;
        for (int i = 0; i < n; i++)
        begin
            lane = {w[16 + i % 16], w[i % 16]}; // Low half on lane 0
            #200 link_clk = 1'b1;
            #200 link_clk = 1'b0;
        end
    endtask : send

    // Idle levels
    initial
    begin
        link_clk = 1'b0;
        lane     = 2'h0;
    end
endmodule : dpo_ser_model

/* bench/dpo_top_tb_top.sv */
// Self-checking bench for the output controller.
// Assumes the serializer model and the bound checker.
`timescale 1ns/1ps
`include "dpo_defs.svh"

module dpo_top_tb_top;
    logic        CORE_CLK, RESETN, LINK_CLK, OUTPUT_EDGE_SELECT, OUTPUT_ENABLE;
    logic        POWER_DOWN_N, RESERVED_TIE_LOW, RECOVERED_DATA_OE_N, RECOVERED_CLOCK_OUT;
    logic        RECOVERED_CLOCK_OE_N, LOCK_OUT, LOCK_OE_N, IRQ, PSEL, PENABLE, PWRITE;
    logic        PREADY, PSLVERR, er;
    logic [1:0]  SERIAL_LANE_IN;
    logic [11:0] PADDR;
    logic [31:0] RECOVERED_DATA_OUT, PWDATA, PRDATA, rd;
    int          failures, samples_checked;

    dpo_top DUT (.*);
    dpo_ser_model u_ser (.link_clk(LINK_CLK), .lane(SERIAL_LANE_IN));

    task summarize;
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        samples_checked++;
        if (got !== ex)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task wt(input int n);
        repeat (n) @(posedge CORE_CLK);
    endtask : wt

    // One APB transfer; the wait for ready is bounded
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge CORE_CLK);
        PSEL    <= 1'b1;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        n = 0;
        do
        begin
            @(posedge CORE_CLK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 16);
        rd = PRDATA;
        er = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        if (PREADY !== 1'b1)
        begin
            failures++;
            summarize();
        end
    endtask : apb

    task t_regs;
        apb(1'b0, `DPO_ADDR_CTRL, 32'h0);
        chk("ctrl reset", 32'h1, rd);
        chk("mapped err", 32'h0, {31'h0, er});
        apb(1'b0, 12'h0f0, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, `DPO_ADDR_IMASK, 32'h2);
        chk("lock idle", 32'h0, {31'h0, LOCK_OUT});
    endtask : t_regs

    task t_words;
        u_ser.send(48, 32'ha5c3_0f81);
        wt(4);
        chk("lock", 32'h1, {31'h0, LOCK_OUT});
        chk("word rise", 32'ha5c3_0f81, RECOVERED_DATA_OUT);
        chk("clock high", 32'h1, {31'h0, RECOVERED_CLOCK_OUT});
        apb(1'b0, `DPO_ADDR_WORD, 32'h0);
        chk("word reg", 32'ha5c3_0f81, rd);
        apb(1'b0, `DPO_ADDR_STAT, 32'h0);
        chk("status locked", 32'h0000_000b, rd);
        OUTPUT_EDGE_SELECT <= 1'b0;
        u_ser.send(16, 32'h3c5a_96e7);
        wt(4);
        chk("word before fall", 32'ha5c3_0f81, RECOVERED_DATA_OUT);
        u_ser.send(10, 32'h0);
        wt(4);
        chk("word after fall", 32'h3c5a_96e7, RECOVERED_DATA_OUT);
        chk("clock low", 32'h0, {31'h0, RECOVERED_CLOCK_OUT});
    endtask : t_words

    task t_loss;
        wt(60);
        chk("lock lost", 32'h0, {31'h0, LOCK_OUT});
        chk("data tri", 32'h1, {31'h0, RECOVERED_DATA_OE_N});
        chk("clock tri", 32'h1, {31'h0, RECOVERED_CLOCK_OE_N});
        chk("irq raised", 32'h1, {31'h0, IRQ});
        apb(1'b0, `DPO_ADDR_ISTAT, 32'h0);
        chk("istat events", 32'h0000_000b, rd);
        apb(1'b1, `DPO_ADDR_IMASK, 32'h0);
        wt(2);
        chk("irq masked", 32'h0, {31'h0, IRQ});
        apb(1'b1, `DPO_ADDR_ISTAT, 32'hf);
        apb(1'b1, `DPO_ADDR_IMASK, 32'h2);
        wt(2);
        chk("irq cleared", 32'h0, {31'h0, IRQ});
        apb(1'b0, `DPO_ADDR_ISTAT, 32'h0);
        chk("istat cleared", 32'h0, rd);
    endtask : t_loss

    task t_enable;
        OUTPUT_EDGE_SELECT <= 1'b1;
        u_ser.send(48, 32'h0);
        wt(1);
        chk("driven", 32'h0, {31'h0, RECOVERED_DATA_OE_N});
        apb(1'b1, `DPO_ADDR_CTRL, 32'h0);
        wt(2);
        chk("soft enable off", 32'h1, {31'h0, RECOVERED_CLOCK_OE_N});
        apb(1'b1, `DPO_ADDR_CTRL, 32'h1);
        OUTPUT_ENABLE <= 1'b0;
        u_ser.send(2, 32'h0);
        chk("enable off", 32'h1, {31'h0, RECOVERED_DATA_OE_N});
        chk("still locked", 32'h1, {31'h0, LOCK_OUT});
        wt(1);
        OUTPUT_ENABLE <= 1'b1;
        POWER_DOWN_N  <= 1'b0;
        u_ser.send(2, 32'h0);
        chk("lock released", 32'h1, {31'h0, LOCK_OE_N});
        chk("standby data", 32'h1, {31'h0, RECOVERED_DATA_OE_N});
        chk("irq on standby", 32'h1, {31'h0, IRQ});
        wt(1);
        POWER_DOWN_N <= 1'b1;
        u_ser.send(4, 32'h0);
        chk("no relock yet", 32'h1, {31'h0, RECOVERED_DATA_OE_N});
        apb(1'b1, `DPO_ADDR_CTRL, 32'h3);
        wt(2);
        chk("soft standby", 32'h1, {31'h0, LOCK_OE_N});
        apb(1'b0, `DPO_ADDR_STAT, 32'h0);
        chk("status standby", 32'h0000_000c, rd);
        apb(1'b1, `DPO_ADDR_CTRL, 32'h1);
        wt(2);
        chk("standby left", 32'h0, {31'h0, LOCK_OE_N});
    endtask : t_enable

    // Core clock, 20 MHz
    initial
    begin
        CORE_CLK = 1'b0;
        forever #25 CORE_CLK = ~CORE_CLK;
    end

    // Main sequence
    initial
    begin
        RESETN             = 1'b0;
        PSEL               = 1'b0;
        PENABLE            = 1'b0;
        PWRITE             = 1'b0;
        PADDR              = 12'h0;
        PWDATA             = 32'h0;
        OUTPUT_EDGE_SELECT = 1'b1;
        OUTPUT_ENABLE      = 1'b1;
        POWER_DOWN_N       = 1'b1;
        RESERVED_TIE_LOW   = 1'b0; // Board keeps it low
        failures           = 0;
        samples_checked    = 0;
        wt(16);
        RESETN <= 1'b1;
        t_regs();
        t_words();
        t_loss();
        t_enable();
        summarize();
    end
endmodule : dpo_top_tb_top
